// file: pcls_defines.svh
// Overview of operation
// - load-complete line driven low within 600 ns of request falling.
// - status line driven low within 600 ns of request falling.
// - status line stays low between 268 us and 1,506 us.
// - status line released within 1,506 us after request rises.
// - user mode entered 175 us to 437 us after load-complete rises.
`ifndef PCLS_DEFINES_SVH
`define PCLS_DEFINES_SVH

`define PCLS_CLK_MHZ          50
`define PCLS_CF2LOW_NS        600
`define PCLS_STATUS_MIN_US    268
`define PCLS_STATUS_MAX_US    1506
`define PCLS_UM_MIN_US        175
`define PCLS_UM_MAX_US        437
`define PCLS_BITS_SMALL       137598880
`define PCLS_BITS_LARGE       213798880
`define PCLS_BUS_WIDTH        32
`define PCLS_RATIO            1

`define PCLS_CF2LOW_CYC       ((`PCLS_CF2LOW_NS * `PCLS_CLK_MHZ) / 1000)
`define PCLS_STATUS_MIN_CYC   (`PCLS_STATUS_MIN_US * `PCLS_CLK_MHZ)
`define PCLS_STATUS_MAX_CYC   (`PCLS_STATUS_MAX_US * `PCLS_CLK_MHZ)
`define PCLS_UM_MIN_CYC       (`PCLS_UM_MIN_US * `PCLS_CLK_MHZ)
`define PCLS_UM_MAX_CYC       (`PCLS_UM_MAX_US * `PCLS_CLK_MHZ)

`endif

// file: pcls_pkg.sv
package pcls_pkg;

  // link pins that arrive from the host, sampled together
  typedef struct packed {
    logic cfgReq_n;
    logic cfgClk;
    logic statusIn;
  } pcls_pins_t;

  typedef enum logic [2:0] {
    PCLS_CLEAR = 3'h0,
    PCLS_WREL  = 3'h1,
    PCLS_LOAD  = 3'h2,
    PCLS_INIT  = 3'h3,
    PCLS_USER  = 3'h4
  } pcls_state_t;

endpackage

// file: pcls_loader.sv
`timescale 1ns/1ns
`include "pcls_defines.svh"

module pcls_loader
  import pcls_pkg::*;
#(
  parameter int WIDTH          = `PCLS_BUS_WIDTH,
  parameter int RATIO          = `PCLS_RATIO,
  parameter int BITS           = `PCLS_BITS_SMALL,
  parameter int STATUS_MIN_CYC = `PCLS_STATUS_MIN_CYC,
  parameter int STATUS_MAX_CYC = `PCLS_STATUS_MAX_CYC,
  parameter int UM_MIN_CYC     = `PCLS_UM_MIN_CYC,
  parameter int UM_MAX_CYC     = `PCLS_UM_MAX_CYC
) (
  // system
  input  wire logic             clk_sys,
  input  wire logic             reset,
  // link pins from the host
  input  wire pcls_pins_t       pinsIn,
  input  wire logic [WIDTH-1:0] cfgData,
  // open-drain status and load-complete lines
  output wire logic             statusOut,
  output wire logic             statusOeN,
  output wire logic             loadDoneOut,
  output wire logic             loadDoneOeN,
  // toward configuration memory
  output wire logic [WIDTH-1:0] wordData,
  output wire logic             wordValid,
  output wire logic             userMode
);

  localparam int WORDS = BITS / WIDTH;
  localparam int TW    = 18;
  localparam logic [TW-1:0] ST_MIN = TW'(STATUS_MIN_CYC - 1);
  localparam logic [TW-1:0] UM_MIN = TW'(UM_MIN_CYC - 1);
  localparam logic [31:0]   W_LAST = 32'(WORDS - 1);
  localparam logic [7:0]    R_LAST = 8'(RATIO - 1);

  // ****************************************
  // pin synchronisers
  // ****************************************
  pcls_pins_t       pinsMeta_r, pinsSync_r;
  logic [WIDTH-1:0] dataMeta_r, dataSync_r;
  logic             clkPrev_r;

  always_ff @(posedge clk_sys) begin
    pinsMeta_r <= pinsIn;
    pinsSync_r <= pinsMeta_r;
    dataMeta_r <= cfgData;
    dataSync_r <= dataMeta_r;
    clkPrev_r  <= pinsSync_r.cfgClk;
  end

  // data sits two flops deep like the clock, so edge and word stay aligned
  wire logic clkRise = pinsSync_r.cfgClk & ~clkPrev_r;
  wire logic reqLow  = ~pinsSync_r.cfgReq_n;

  // ****************************************
  // sequencer
  // ****************************************
  pcls_state_t      state_r, state_nxt;
  logic [TW-1:0]    timer_r, timer_nxt;
  logic [31:0]      words_r, words_nxt;
  logic [7:0]       phase_r, phase_nxt;
  logic             statusOeN_r, statusOeN_nxt;
  logic             doneOeN_r, doneOeN_nxt;
  logic             user_r, user_nxt;
  logic [WIDTH-1:0] wordData_r, wordData_nxt;
  logic             wordValid_r, wordValid_nxt;

  always_comb begin
    state_nxt     = state_r;
    timer_nxt     = timer_r;
    words_nxt     = words_r;
    phase_nxt     = phase_r;
    statusOeN_nxt = statusOeN_r;
    doneOeN_nxt   = doneOeN_r;
    user_nxt      = user_r;
    wordData_nxt  = wordData_r;
    wordValid_nxt = 1'b0;
    if (reqLow) begin
      state_nxt     = PCLS_CLEAR;
      timer_nxt     = '0;
      statusOeN_nxt = 1'b0;
      doneOeN_nxt   = 1'b0;
      user_nxt      = 1'b0;
    end else begin
      case (state_r)
        PCLS_CLEAR, PCLS_WREL: begin
          // minimum low time counts from the request rise, so a long request only adds to it
          if (timer_r >= ST_MIN) begin
            state_nxt     = PCLS_LOAD;
            statusOeN_nxt = 1'b1;
            words_nxt     = '0;
            phase_nxt     = '0;
          end else begin
            state_nxt = PCLS_WREL;
            timer_nxt = timer_r + TW'(1);
          end
        end
        PCLS_LOAD: begin
          // an outside low on status postpones loading, edges are ignored
          if (clkRise && pinsSync_r.statusIn) begin
            if (phase_r == R_LAST) begin
              phase_nxt     = '0;
              wordData_nxt  = dataSync_r;
              wordValid_nxt = 1'b1;
              words_nxt     = words_r + 32'h0000_0001;
              if (words_r == W_LAST) begin
                state_nxt   = PCLS_INIT;
                doneOeN_nxt = 1'b1;
                timer_nxt   = '0;
              end
            end else begin
              phase_nxt = phase_r + 8'h01;
            end
          end
        end
        PCLS_INIT: begin
          // initialisation runs on the own clock, not on host edges
          if (timer_r >= UM_MIN) begin
            state_nxt = PCLS_USER;
            user_nxt  = 1'b1;
          end else begin
            timer_nxt = timer_r + TW'(1);
          end
        end
        PCLS_USER: begin
          user_nxt = 1'b1;
        end
        default: begin
          state_nxt = PCLS_CLEAR;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_r     <= PCLS_CLEAR;
      timer_r     <= '0;
      words_r     <= '0;
      phase_r     <= '0;
      statusOeN_r <= 1'b0;
      doneOeN_r   <= 1'b0;
      user_r      <= 1'b0;
      wordData_r  <= '0;
      wordValid_r <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      timer_r     <= timer_nxt;
      words_r     <= words_nxt;
      phase_r     <= phase_nxt;
      statusOeN_r <= statusOeN_nxt;
      doneOeN_r   <= doneOeN_nxt;
      user_r      <= user_nxt;
      wordData_r  <= wordData_nxt;
      wordValid_r <= wordValid_nxt;
    end
  end

  assign statusOut   = 1'b0;
  assign statusOeN   = statusOeN_r;
  assign loadDoneOut = 1'b0;
  assign loadDoneOeN = doneOeN_r;
  assign wordData    = wordData_r;
  assign wordValid   = wordValid_r;
  assign userMode    = user_r;

  // ****************************************
  // checks
  // ****************************************
  logic [TW-1:0] lowCnt_r, relCnt_r, umCnt_r;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      lowCnt_r <= '0;
      relCnt_r <= '0;
      umCnt_r  <= '0;
    end else begin
      lowCnt_r <= statusOeN_r ? '0 : lowCnt_r + TW'(1);
      relCnt_r <= (statusOeN_r || reqLow) ? '0 : relCnt_r + TW'(1);
      umCnt_r  <= (!doneOeN_r || user_r) ? '0 : umCnt_r + TW'(1);
    end
  end

  sequence s_reqFall;
    $fell(pinsSync_r.cfgReq_n);
  endsequence

  property p_doneLow;
    @(posedge clk_sys) disable iff (reset)
      s_reqFall |-> ##[1:2] !loadDoneOeN;
  endproperty
  a_doneLow: assert property (p_doneLow) else $error("load-complete not low in time");

  property p_statusLow;
    @(posedge clk_sys) disable iff (reset)
      s_reqFall |-> ##[1:2] (!statusOeN && !userMode);
  endproperty
  a_statusLow: assert property (p_statusLow) else $error("status not low in time");

  property p_statusMin;
    @(posedge clk_sys) disable iff (reset)
      $rose(statusOeN) |-> $past(lowCnt_r) >= ST_MIN;
  endproperty
  a_statusMin: assert property (p_statusMin) else $error("status low too short");

  property p_statusMax;
    @(posedge clk_sys) disable iff (reset)
      relCnt_r <= TW'(STATUS_MAX_CYC);
  endproperty
  a_statusMax: assert property (p_statusMax) else $error("status release too late");

  property p_userWin;
    @(posedge clk_sys) disable iff (reset)
      $rose(userMode) |-> ($past(umCnt_r) >= UM_MIN) && ($past(umCnt_r) < TW'(UM_MAX_CYC));
  endproperty
  a_userWin: assert property (p_userWin) else $error("user mode outside window");

  property p_doneFirst;
    @(posedge clk_sys) disable iff (reset)
      userMode |-> loadDoneOeN && statusOeN;
  endproperty
  a_doneFirst: assert property (p_doneFirst) else $error("user mode before load done");

endmodule

// file: pcls_host.sv
`timescale 1ns/1ns
module pcls_host
  import pcls_pkg::*;
(
  // device side
  input  wire logic        statusOeN,
  // host pins
  output pcls_pins_t       pins,
  output logic [31:0]      data
);
  // ********************
  // host pin state
  // ********************
  logic reqN  = 1'b1;
  logic clk   = 1'b0;
  logic holdN = 1'b1;
  initial data = 32'h0;
  // open status wire: low if either party pulls
  assign pins = '{reqN, clk, statusOeN & holdN};

  task automatic request(input int lowNs);
    reqN = 1'b0;
    #(lowNs);
    reqN = 1'b1;
  endtask

  // 160 ns period; plain ratio, no compression or security in use
  task automatic send(input int n, input logic [31:0] base);
    for (int i = 0; i < n; i++) begin
      data = base + i;
      #80 clk = 1'b1;
      #80 clk = 1'b0;
    end
    data = ~data;
  endtask
endmodule

// file: test_parallel_config_load_sequencer.sv
`timescale 1ns/1ns
module test_parallel_config_load_sequencer;
  import pcls_pkg::*;
  // ********************
  // clock, reset, wiring
  // ********************
  logic        clk_sys = 1'b0;
  logic        reset   = 1'b1;
  pcls_pins_t  pins;
  logic [31:0] cfgData, wordData, lastWord;
  logic        statusOut, statusOeN, loadDoneOut, loadDoneOeN, wordValid, userMode;
  int          num_errors = 0, checks = 0, nWords = 0, cycles = 0;
  always #10 clk_sys = ~clk_sys;

  pcls_loader #(.BITS(256), .STATUS_MIN_CYC(20), .STATUS_MAX_CYC(200),
    .UM_MIN_CYC(20)) dut (.clk_sys(clk_sys), .reset(reset),
    .pinsIn(pins), .cfgData(cfgData), .statusOut(statusOut), .statusOeN(statusOeN),
    .loadDoneOut(loadDoneOut), .loadDoneOeN(loadDoneOeN), .wordData(wordData),
    .wordValid(wordValid), .userMode(userMode));
  pcls_host host (.statusOeN(statusOeN), .pins(pins), .data(cfgData));

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (wordValid === 1'b1) begin
      nWords   <= nWords + 1;
      lastWord <= wordData;
    end
    if (cycles == 5000) begin
      num_errors = num_errors + 1;
      conclude();
    end
  end

  // ********************
  // shared tasks
  // ********************
  task automatic check(input string what, input logic [31:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // ********************
  // scenarios
  // ********************
  // request from any state; edges while status is low are refused
  task automatic t_start();
    int n;
    int w0;
    w0 = nWords;
    @(negedge clk_sys);
    fork host.request(2000); join_none
    #600;
    check("statusOeN", statusOeN, 1'b0);
    check("loadDoneOeN", loadDoneOeN, 1'b0);
    check("userMode", userMode, 1'b0);
    check("statusOut", statusOut, 1'b0);
    check("loadDoneOut", loadDoneOut, 1'b0);
    host.send(2, 32'hAA00);
    check("earlyWords", nWords, w0);
    wait (pins.cfgReq_n === 1'b1);
    n = 0;
    while (statusOeN !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check("releaseWait", n <= 200, 1'b1);
    // then act as a host that ignores status: sit out the longest release time
    while (n < 200) begin
      @(negedge clk_sys);
      n++;
    end
  endtask

  // load 8 words, optionally paused by an outside hold on status
  task automatic t_load(input bit hold);
    int n;
    int w0;
    w0 = nWords;
    #2000;
    if (hold) begin
      host.send(4, 32'h1000);
      host.holdN = 1'b0;
      host.send(2, 32'h2000);
      check("pausedWords", nWords - w0, 4);
      host.holdN = 1'b1;
      #2000;
      host.send(4, 32'h1004);
    end else begin
      host.send(8, 32'h1000);
    end
    n = 0;
    while (loadDoneOeN !== 1'b1 && n < 20) begin
      @(negedge clk_sys);
      n++;
    end
    check("words", nWords - w0, 8);
    check("lastWord", lastWord, 32'h1007);
    check("loadDone", loadDoneOeN, 1'b1);
    n = 0;
    while (userMode !== 1'b1 && n < 100) begin
      @(negedge clk_sys);
      n++;
    end
    check("userDelay", n >= 18 && n <= 60, 1'b1);
  endtask

  initial begin
    int n;
    repeat (16) @(negedge clk_sys);
    check("resetStatus", statusOeN, 1'b0);
    reset = 1'b0;
    n = 0;
    while (statusOeN !== 1'b1 && n < 300) begin
      @(negedge clk_sys);
      n++;
    end
    check("statusLow", n >= 18 && n <= 200, 1'b1);
    t_load(1'b0);
    t_start();
    // a cut load must not leave its word count behind for the next one
    host.send(3, 32'h3000);
    t_start();
    t_load(1'b1);
    conclude();
  end
endmodule
